/* verilog/rlink_codec.v */
`timescale 1ns/1ps
`include "rlink_map.vh"
module rlink_codec (
  input wire mclk, // system clock, 50 MHz
  input wire nrst, // async reset, active low
  input wire ce, // clock enable, freezes all state when low
  input wire [3:0] address, // avalon word address
  input wire read, // avalon read
  input wire write, // avalon write
  input wire [31:0] writedata, // avalon write data
  input wire [3:0] byteenable, // avalon byte enables
  output reg [31:0] readdata, // avalon read data
  output wire waitrequest, // avalon wait
  output reg [7:0] tx_byte, // payload byte out
  output reg tx_valid, // payload byte valid
  output reg tx_first, // first byte of payload
  output reg tx_last, // last byte of payload
  output reg [12:0] tx_pid, // packet identifier of payload
  input wire tx_ready, // sink accepts byte
  output reg [1:0] link_mode, // link operating mode field for every packet
  input wire beacon_ack, // remote acknowledges beacon mode
  output wire metrics_enable, // control metrics may be exchanged
  output reg link_default, // acknowledgement lost past time-out
  input wire [7:0] rx_byte, // incoming request byte
  input wire rx_valid, // incoming byte valid
  input wire rx_first, // incoming first byte
  input wire rx_last // incoming last byte
);
  reg [31:0] ctrl_r;
  reg [31:0] req_r;
  reg [31:0] req_ext_r;
  reg [31:0] timeout_r;
  reg [7:0] wm_count_r;
  reg [31:0] wm_mem [0:`WM_DEPTH-1];
  reg [3:0] wm_wr_r;
  reg [31:0] decode_r;
  reg dec_valid_r;
  reg dec_err_r;
  reg busy_r;
  reg [1:0] kind_r;
  reg [9:0] idx_r;
  reg [3:0] len_r;
  reg [31:0] lost_cnt_r;
  reg ack_seen_r;
  reg [3:0] rx_idx_r;
  reg [7:0] rx_type_r;
  reg [7:0] rx_hold_r;
  reg [95:0] frame;
  reg [7:0] byte_nxt;
  reg ack_r;
  reg [9:0] wm_pos;
  reg [31:0] wm_word;
  localparam K_MODE = 2'h0;
  localparam K_WM = 2'h1;
  // type of the request in flight, including the byte on the wire right now
  wire [7:0] type_cur = (rx_idx_r == 4'h1 && !rx_first) ? rx_byte : rx_type_r;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  function [3:0] req_len;
    input [7:0] t;
    begin
      case (t)
        `TYPE_FM: req_len = `LEN_FM;
        `TYPE_MC: req_len = `LEN_MC;
        `TYPE_VSB: req_len = `LEN_VSB;
        `TYPE_SC: req_len = `LEN_SC;
        default: req_len = `LEN_GENERIC;
      endcase
    end
  endfunction

  // one wait state per access; answered the cycle after the request appears
  assign waitrequest = (read | write) & ~(ack_r & ce);
  wire acc = (read | write) & ack_r & ce;
  wire wr = write & acc;
  assign metrics_enable = link_mode == `MODE_BEACON && ack_seen_r && !link_default;

  // payload image, MSB first, reserved bits forced to zero
  always @* begin
    frame = 96'h0;
    frame[95:88] = req_r[7:0];
    frame[87:80] = req_r[15:8];
    case (req_r[15:8])
      `TYPE_FM: frame[79] = req_ext_r[0];
      `TYPE_MC: frame[79:71] = {req_ext_r[1:0], req_ext_r[3:2], req_ext_r[5:4],
                                req_ext_r[8:6]};
      `TYPE_VSB: frame[79:72] = {req_ext_r[2:0], req_ext_r[12:8]};
      `TYPE_SC: frame[79:68] = {req_ext_r[12:8], req_ext_r[2:0], req_ext_r[19:16]};
      default: frame[79:0] = 80'h0;
    endcase
    // counts past the memory depth wrap onto the stored words
    wm_pos = idx_r - 10'h001;
    wm_word = wm_mem[wm_pos[5:2]];
    byte_nxt = 8'h00;
    if (kind_r == K_MODE)
      byte_nxt = frame[95 - idx_r[3:0]*8 -: 8];
    else if (idx_r == 10'h000)
      byte_nxt = wm_count_r;
    else begin
      case (wm_pos[1:0])
        2'h0: byte_nxt = wm_word[31:24];
        2'h1: byte_nxt = wm_word[23:16];
        2'h2: byte_nxt = wm_word[15:8];
        default: byte_nxt = wm_word[7:0];
      endcase
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      readdata <= 32'h0;
      ctrl_r <= 32'h1;
      req_r <= 32'h0;
      req_ext_r <= 32'h0;
      timeout_r <= `TIMEOUT_RST;
      wm_count_r <= 8'h0;
      wm_wr_r <= 4'h0;
      busy_r <= 1'b0;
      kind_r <= K_MODE;
      idx_r <= 10'h000;
      len_r <= 4'h0;
      tx_byte <= 8'h0;
      tx_valid <= 1'b0;
      tx_first <= 1'b0;
      tx_last <= 1'b0;
      tx_pid <= 13'h0;
      link_mode <= `MODE_BEACON;
      link_default <= 1'b0;
      lost_cnt_r <= 32'h0;
      ack_seen_r <= 1'b0;
      decode_r <= 32'h0;
      dec_valid_r <= 1'b0;
      dec_err_r <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_type_r <= 8'h0;
      rx_hold_r <= 8'h0;
    end else if (ce) begin
      ack_r <= (read | write) & ~ack_r;
      // loaded in the wait cycle so the data stand at the edge that ends the wait
      if (read && !ack_r) begin
        case (address)
          `REG_CTRL: readdata <= ctrl_r;
          `REG_STATUS: readdata <= {24'h0, metrics_enable, dec_err_r, dec_valid_r,
                                   link_default, ack_seen_r, busy_r, link_mode};
          `REG_REQ: readdata <= req_r;
          `REG_TIMEOUT: readdata <= timeout_r;
          `REG_WM_COUNT: readdata <= {24'h0, wm_count_r};
          `REG_DECODE: readdata <= decode_r;
          default: readdata <= 32'h0;
        endcase
      end
      if (wr) begin
        case (address)
          `REG_CTRL: ctrl_r <= merge(ctrl_r, writedata, byteenable);
          `REG_REQ: req_r <= merge(req_r, writedata, byteenable);
          `REG_TIMEOUT: timeout_r <= merge(timeout_r, writedata, byteenable);
          `REG_WM_COUNT: begin
            wm_count_r <= writedata[7:0];
            wm_wr_r <= 4'h0;
          end
          `REG_WM_DATA: wm_wr_r <= wm_wr_r + 4'h1;
          `REG_DECODE: ;
          default: ;
        endcase
        if (address == `REG_REQ_EXT)
          req_ext_r <= writedata;
      end
      // ctrl bit0 beacon default on, bit1 send request, bit2 send watermarks
      link_mode <= ctrl_r[0] ? `MODE_BEACON : `MODE_IDLE;
      if (!busy_r && ctrl_r[2:1] != 2'b00) begin
        busy_r <= 1'b1;
        idx_r <= 10'h000;
        // a new send written in the launch cycle survives the self-clear
        if (ctrl_r[1]) begin
          kind_r <= K_MODE;
          tx_pid <= `PID_MODE_CMD;
          len_r <= req_len(req_r[15:8]);
          if (!(wr && address == `REG_CTRL && byteenable[0] && writedata[1]))
            ctrl_r[1] <= 1'b0;
        end else begin
          kind_r <= K_WM;
          tx_pid <= `PID_WATERMARK;
          if (!(wr && address == `REG_CTRL && byteenable[0] && writedata[2]))
            ctrl_r[2] <= 1'b0;
        end
      end else if (busy_r && (!tx_valid || tx_ready)) begin
        if ((kind_r == K_MODE && idx_r[3:0] == len_r) ||
            (kind_r == K_WM && idx_r == {wm_count_r, 2'b00} + 10'h001) ||
            (tx_valid && tx_last)) begin
          tx_valid <= 1'b0;
          busy_r <= tx_valid & tx_last ? 1'b0 : busy_r;
          tx_last <= 1'b0;
        end else begin
          tx_byte <= byte_nxt;
          tx_valid <= 1'b1;
          tx_first <= idx_r == 10'h000;
          tx_last <= kind_r == K_MODE ? idx_r[3:0] == len_r - 4'h1
                     : idx_r == {wm_count_r, 2'b00};
          idx_r <= idx_r + 10'h001;
        end
      end
      // beacon acknowledgement supervision with user time-out
      if (beacon_ack) begin
        ack_seen_r <= 1'b1;
        lost_cnt_r <= 32'h0;
        link_default <= 1'b0;
      end else if (ack_seen_r) begin
        if (lost_cnt_r >= timeout_r)
          link_default <= 1'b1;
        else
          lost_cnt_r <= lost_cnt_r + 32'h1;
      end
      // request parser: decode tags, flag reserved types in dec_err_r
      if (rx_valid) begin
        rx_idx_r <= rx_first ? 4'h1 : rx_idx_r + 4'h1;
        if (rx_first)
          rx_hold_r <= rx_byte;
        if (rx_idx_r == 4'h1 && !rx_first) begin
          rx_type_r <= rx_byte;
          decode_r <= {16'h0, rx_byte, rx_hold_r};
        end
        if (rx_idx_r == 4'h2 && !rx_first)
          decode_r <= {8'h0, rx_byte, rx_type_r, rx_hold_r};
        if (rx_last) begin
          if (type_cur > `TYPE_SC)
            dec_err_r <= 1'b1;
          else
            dec_valid_r <= 1'b1;
        end
      end
      if (wr && address == `REG_STATUS) begin
        if (writedata[5] && !(rx_valid && rx_last && type_cur <= `TYPE_SC))
          dec_valid_r <= 1'b0;
        if (writedata[6] && !(rx_valid && rx_last && type_cur > `TYPE_SC))
          dec_err_r <= 1'b0;
      end
    end
  end

  always @(posedge mclk) begin
    if (ce && wr && address == `REG_WM_DATA)
      wm_mem[wm_wr_r] <= writedata;
  end
endmodule

/* verilog/rlink_map.vh */
`ifndef RLINK_MAP_VH
`define RLINK_MAP_VH
`define PID_MODE_CMD 13'h0012
`define PID_WATERMARK 13'h0013
`define TYPE_GENERIC 8'h00
`define TYPE_FM 8'h01
`define TYPE_MC 8'h02
`define TYPE_VSB 8'h03
`define TYPE_SC 8'h04
`define FM_BW_3MHZ 1'b0
`define FM_BW_4MHZ 1'b1
`define BW_VSB_STD 5'h06
`define MODE_BEACON 2'h1
`define MODE_IDLE 2'h0
`define LEN_GENERIC 4'h2
`define LEN_FM 4'h3
`define LEN_MC 4'h4
`define LEN_VSB 4'h7
`define LEN_SC 4'h8
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_REQ 4'h2
`define REG_TIMEOUT 4'h3
`define REG_WM_COUNT 4'h4
`define REG_WM_DATA 4'h5
`define REG_DECODE 4'h6
`define REG_REQ_EXT 4'hA
`define TIMEOUT_RST 32'h02FAF080
`define WM_DEPTH 16
`endif

/* tb/codec_props.sv */
`timescale 1ns/1ps
module codec_props (
  input wire mclk, // clock
  input wire nrst, // reset
  input wire read, // bus read
  input wire write, // bus write
  input wire waitrequest, // bus wait
  input wire [7:0] tx_byte, // byte out
  input wire tx_valid, // byte valid
  input wire tx_first, // first byte
  input wire tx_last, // last byte
  input wire tx_ready, // byte taken
  input wire [12:0] tx_pid, // packet id
  input wire [1:0] link_mode, // mode field
  input wire beacon_ack, // remote ack
  input wire metrics_enable, // metrics gate
  input wire link_default // fallback
);
  // the bench never programs a time-out shorter than this
  localparam int MIN_LOST = 16;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  reg [7:0] lost_r;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      lost_r <= 8'h00;
    else if (beacon_ack)
      lost_r <= 8'h00;
    else if (lost_r != 8'hFF)
      lost_r <= lost_r + 8'h01;
  end
  sequence req_rise;
    $rose(read || write);
  endsequence
  sequence one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  a_one_wait: assert property (req_rise |-> one_wait) else $error("wait state wrong");
  a_beacon_default: assert property ($rose(nrst) |-> link_mode == 2'h1)
    else $error("mode after reset");
  a_mode_field: assert property (link_mode == 2'h1 || link_mode == 2'h0)
    else $error("mode field value");
  a_metrics_gate: assert property (metrics_enable |-> link_mode == 2'h1 && !link_default)
    else $error("metrics without beacon");
  a_slow_default: assert property ($rose(link_default) |-> lost_r >= MIN_LOST)
    else $error("early fallback");
  a_ack_holds: assert property (beacon_ack [*2] |=> !$rose(link_default))
    else $error("fallback with ack");
  a_pid_known: assert property (tx_valid |-> tx_pid == 13'h0012 || tx_pid == 13'h0013)
    else $error("bad packet id");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte dropped");
  a_frame_opens: assert property ($rose(tx_valid) |-> tx_first)
    else $error("frame without first byte");
  a_frame_closes: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("bytes after last");
endmodule

/* tb/remote_tx_model.sv */
`timescale 1ns/1ps
module remote_tx_model (
  input wire mclk, // clock
  input wire [7:0] tx_byte, // byte in
  input wire tx_valid, // byte valid
  input wire [12:0] tx_pid, // packet id
  output logic tx_ready, // accept
  input wire [1:0] link_mode, // mode field
  output wire beacon_ack, // ack
  input wire ack_on, // bench ack
  input wire slow, // stall
  output logic [7:0] rx_byte, // request byte
  output logic rx_valid, // valid
  output logic rx_first, // first
  output logic rx_last // last
);
  logic [7:0] got[$];
  logic [12:0] pid[$];
  assign beacon_ack = ack_on && link_mode == 2'h1;
  initial begin
    tx_ready = 1'b1;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_last = 1'b0;
  end
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_byte);
      pid.push_back(tx_pid);
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task send(input logic [23:0] b);
    for (int i = 0; i < 3; i++) begin
      rx_byte <= b[23-8*i -: 8];
      rx_valid <= 1'b1;
      rx_first <= i == 0;
      rx_last <= i == 2;
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    rx_byte <= ~b[7:0];
  endtask
endmodule

/* tb/test_return_link_mode_command_codec.sv */
`timescale 1ns/1ps
module test_return_link_mode_command_codec;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic ack_on = 1'b0;
  logic slow = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] q;
  wire [31:0] readdata;
  wire [7:0] tx_byte, rx_byte;
  wire [12:0] tx_pid;
  wire [1:0] link_mode;
  wire waitrequest, tx_valid, tx_ready, beacon_ack, metrics_enable, link_default;
  wire rx_valid, rx_first, rx_last;
  int n_errors = 0;
  int total_checks = 0;
  int len_tbl [5] = '{2, 3, 4, 7, 8};
  logic [31:0] ext_tbl [5] = '{32'h0, 32'h1, 32'h11E, 32'h602, 32'h41F03};
  logic [63:0] exp_tbl [5] = '{64'hF600_0000_0000_0000, 64'hF601_8000_0000_0000,
    64'hF602_B600_0000_0000, 64'hF603_4600_0000_0000, 64'hF604_FB40_0000_0000};
  always #10 mclk = ~mclk;
  rlink_codec dut (.mclk(mclk), .nrst(nrst), .ce(1'b1), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_first(),
    .tx_last(), .tx_pid(tx_pid), .tx_ready(tx_ready), .link_mode(link_mode),
    .beacon_ack(beacon_ack), .metrics_enable(metrics_enable), .link_default(link_default),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first), .rx_last(rx_last));
  remote_tx_model far (.mclk(mclk), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_pid(tx_pid),
    .tx_ready(tx_ready), .link_mode(link_mode), .beacon_ack(beacon_ack), .ack_on(ack_on),
    .slow(slow), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first), .rx_last(rx_last));
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    i = 0;
    r = 32'h0;
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    @(posedge mclk);
    // values read right after the edge are the ones the design sampled there
    while (waitrequest !== 1'b0 && i < 50) begin
      @(posedge mclk);
      i++;
    end
    if (i == 50) begin
      n_errors++;
      print_verdict;
    end else begin
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task wait_bytes(input int n);
    int i;
    i = 0;
    while (far.got.size() < n && i < 300) begin
      @(posedge mclk);
      i++;
    end
    if (i == 300) begin
      n_errors++;
      print_verdict;
    end
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 4'h1, 32'h0, q);
    cmp("status", 32'h1, q & 32'h9B);
    bus(1'b0, 4'hF, 32'h0, q);
    cmp("unmapped", 32'h0, q);
    bus(1'b1, 4'h3, 32'h14, q);
    ack_on <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 4'h1, 32'h0, q);
    cmp("ack status", 32'h89, q & 32'h89);
    for (int t = 0; t < 5; t++) begin
      slow <= t[0];
      far.got.delete();
      far.pid.delete();
      bus(1'b1, 4'h2, {16'h0, t[7:0], 8'hF6}, q);
      bus(1'b1, 4'hA, ext_tbl[t], q);
      bus(1'b1, 4'h0, 32'h3, q);
      wait_bytes(len_tbl[t]);
      cmp("pid", 32'h12, {19'h0, far.pid[0]});
      for (int i = 0; i < len_tbl[t]; i++)
        cmp("byte", {24'h0, exp_tbl[t][63-8*i -: 8]}, {24'h0, far.got[i]});
    end
    far.got.delete();
    far.pid.delete();
    bus(1'b1, 4'h4, 32'h2, q);
    bus(1'b1, 4'h5, 32'hA1B2C3D4, q);
    bus(1'b1, 4'h5, 32'h0102E3F4, q);
    bus(1'b1, 4'h0, 32'h5, q);
    wait_bytes(9);
    cmp("wm pid", 32'h13, {19'h0, far.pid[8]});
    cmp("wm count", 32'h2, {24'h0, far.got[0]});
    cmp("wm one", 32'hA1B2C3D4, {far.got[1], far.got[2], far.got[3], far.got[4]});
    cmp("wm two", 32'h0102E3F4, {far.got[5], far.got[6], far.got[7], far.got[8]});
    far.send(24'hF60346);
    bus(1'b0, 4'h6, 32'h0, q);
    cmp("decode", 32'h004603F6, q);
    far.send(24'hF60755);
    bus(1'b0, 4'h1, 32'h0, q);
    cmp("reserved type", 32'h60, q & 32'h60);
    bus(1'b1, 4'h1, 32'h60, q);
    bus(1'b0, 4'h1, 32'h0, q);
    cmp("flags cleared", 32'h0, q & 32'h60);
    ack_on <= 1'b0;
    repeat (3) @(posedge mclk);
    ack_on <= 1'b1;
    bus(1'b0, 4'h1, 32'h0, q);
    cmp("brief loss", 32'h80, q & 32'h90);
    ack_on <= 1'b0;
    repeat (30) @(posedge mclk);
    bus(1'b0, 4'h1, 32'h0, q);
    cmp("fallback", 32'h10, q & 32'h90);
    print_verdict;
  end
endmodule
bind rlink_codec codec_props chk (.mclk(mclk), .nrst(nrst), .read(read), .write(write),
  .waitrequest(waitrequest), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_first(tx_first),
  .tx_last(tx_last), .tx_ready(tx_ready),
  .tx_pid(tx_pid), .link_mode(link_mode), .beacon_ack(beacon_ack),
  .metrics_enable(metrics_enable), .link_default(link_default));
